// ==== core/mss_sensor.sv ====
/*
 * mss_sensor: sensor end of the serial port, with motion accumulation,
 * motion pin and motion burst snapshot.
 * Assumes the link pins come from another clock domain and that user-side
 * inputs are on ref_clk_i; reg_rdata_i follows reg_addr_o combinationally.
 */
// Notes on behaviour
// - sensor only answers, never starts transfers
// - select high: ignore inputs, release data out
// - motion pin low while motion bit set
// - reading all deltas or motion write clears
// - select rising aborts, port returns idle
// - host keeps gaps even after abort
// - host frames each transaction with select
// - after burst, port locked until select rises
// - write is address byte, MSB one, data
// - data in sampled on clock rising edges
// - read is address MSB zero, data back
// - data out changes on clock falling edges
// - host keeps write-to-write gap
// - host keeps write-to-read gap
// - host pauses clock before read data
// - host keeps gap after each read
// - burst streams bytes without addresses or gaps
// - burst starts with address 0x50
// - host waits one frame before burst data
// - burst report snapshot at last address bit
// - fourteen burst bytes in fixed order
// - no transaction after burst until select reset
// - host clears residual motion after bursts (mss_host does not; the burst's delta byte reads clear it in the sensor)
`timescale 1ns/10ps
`default_nettype none
module mss_sensor (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // serial link
    mss_if.sensor link,
    // motion input
    input wire logic delta_add_i,
    input wire logic [15:0] delta_x_i,
    input wire logic [15:0] delta_y_i,
    // frame statistics
    input wire logic [7:0] observation_i,
    input wire logic [7:0] surface_quality_i,
    input wire logic [7:0] pixel_sum_i,
    input wire logic [7:0] max_pixel_i,
    input wire logic [7:0] min_pixel_i,
    input wire logic [15:0] shutter_i,
    input wire logic [15:0] frame_period_i,
    // other registers
    output logic [6:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i,
    // motion pin
    output logic motion_n_o
);
    import mss_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mss_dst_e st;
        logic [2:0] cnt;
        logic [7:0] a;
        logic [7:0] sh;
        logic [3:0] bidx;
        logic [BURST_BYTES-1:0][7:0] snap;
        logic sclk_p;
        logic miso;
        logic oe;
        logic [15:0] dx;
        logic [15:0] dy;
        logic mot;
        logic mot_n;
        logic [3:0] rmask;
        logic [6:0] raddr;
        logic wr;
        logic [7:0] wdata;
    } mss_dev_s;

    localparam mss_dev_s DEV_RST = '{
        st: MSS_D_IDLE, cnt: 3'h0, a: RESET_BYTE, sh: RESET_BYTE,
        bidx: 4'h0, snap: '0, sclk_p: 1'b1, miso: 1'b0, oe: 1'b0,
        dx: RESET_WORD, dy: RESET_WORD, mot: 1'b0, mot_n: 1'b1,
        rmask: 4'h0, raddr: 7'h00, wr: 1'b0, wdata: RESET_BYTE};

    mss_dev_s q;
    mss_dev_s d;
    logic [2:0] pins_s;
    logic sclk_s;
    logic mosi_s;
    logic sel_n_s;
    logic rise;
    logic fall;
    logic clr;
    logic [7:0] nxt;
    logic [7:0] byt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // register read for the single-byte path
    function automatic logic [7:0] rd_fn(input logic [6:0] ad, input logic m,
            input logic [15:0] x, input logic [15:0] y, input logic [7:0] ext);
        case (ad)
            MOTION_ADDR: rd_fn = {m, 7'h00};
            DX_L_ADDR: rd_fn = x[7:0];
            DX_H_ADDR: rd_fn = x[15:8];
            DY_L_ADDR: rd_fn = y[7:0];
            DY_H_ADDR: rd_fn = y[15:8];
            default: rd_fn = ext;
        endcase
    endfunction

    // which delta byte a read consumes
    function automatic logic [3:0] mask_fn(input logic [6:0] ad);
        case (ad)
            DX_L_ADDR: mask_fn = 4'h1;
            DX_H_ADDR: mask_fn = 4'h2;
            DY_L_ADDR: mask_fn = 4'h4;
            DY_H_ADDR: mask_fn = 4'h8;
            default: mask_fn = 4'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    mss_sync #(.W(3), .INIT(3'b101)) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .d_i({link.sclk, link.mosi, link.port_select_n}),
        .q_o(pins_s)
    );

    // edges of the sampled serial clock
    assign sclk_s = pins_s[2];
    assign mosi_s = pins_s[1];
    assign sel_n_s = pins_s[0];
    assign rise = sclk_s & ~q.sclk_p;
    assign fall = ~sclk_s & q.sclk_p;
    assign nxt = {q.a[6:0], mosi_s};
    assign clr = (q.rmask == ALL_DELTAS_READ) | (q.wr & (q.raddr == MOTION_ADDR));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        byt = q.sh;
        d.sclk_p = sclk_s;
        d.wr = 1'b0;
        if (sel_n_s) begin
            d.st = MSS_D_IDLE;
            d.cnt = 3'h0;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                MSS_D_IDLE: begin
                    d.st = MSS_D_ADDR;
                    d.cnt = 3'h0;
                end
                MSS_D_ADDR: begin
                    if (rise) begin
                        d.a = nxt;
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == 3'h7) begin
                            d.raddr = nxt[6:0];
                            if (nxt[DIR_BIT]) begin
                                d.st = MSS_D_WDATA;
                            end else if (nxt[6:0] == BURST_ADDR) begin
                                d.st = MSS_D_BURST;
                                d.bidx = 4'h0;
                                d.snap[0] = {q.mot, 7'h00};
                                d.snap[1] = observation_i;
                                d.snap[2] = q.dx[7:0];
                                d.snap[3] = q.dx[15:8];
                                d.snap[4] = q.dy[7:0];
                                d.snap[5] = q.dy[15:8];
                                d.snap[6] = surface_quality_i;
                                d.snap[7] = pixel_sum_i;
                                d.snap[8] = max_pixel_i;
                                d.snap[9] = min_pixel_i;
                                d.snap[10] = shutter_i[15:8];
                                d.snap[11] = shutter_i[7:0];
                                d.snap[12] = frame_period_i[15:8];
                                d.snap[13] = frame_period_i[7:0];
                            end else begin
                                d.st = MSS_D_RDATA;
                            end
                        end
                    end
                end
                MSS_D_WDATA: begin
                    if (rise) begin
                        d.a = nxt;
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == 3'h7) begin
                            d.wdata = nxt;
                            d.wr = 1'b1;
                            d.st = MSS_D_ADDR;
                        end
                    end
                end
                MSS_D_RDATA, MSS_D_BURST: begin
                    if (fall) begin
                        if (q.cnt == 3'h0) begin
                            if (q.st == MSS_D_RDATA) begin
                                byt = rd_fn(q.raddr, q.mot, q.dx, q.dy, reg_rdata_i);
                                d.rmask = q.rmask | mask_fn(q.raddr);
                            end else begin
                                byt = q.snap[q.bidx];
                                d.rmask = q.rmask | mask_fn(7'(q.bidx) + 7'h01);
                                d.bidx = q.bidx + 4'h1;
                            end
                        end
                        d.miso = byt[7];
                        d.sh = {byt[6:0], 1'b0};
                        d.oe = 1'b1;
                    end else if (rise) begin
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == 3'h7) begin
                            if (q.st == MSS_D_RDATA) begin
                                d.st = MSS_D_ADDR;
                                d.oe = 1'b0;
                            end else if (q.bidx == 4'(BURST_BYTES)) begin
                                d.st = MSS_D_LOCK;
                                d.oe = 1'b0;
                            end
                        end
                    end
                end
                MSS_D_LOCK: begin
                    d.oe = 1'b0;
                end
                default: begin
                    d.st = MSS_D_IDLE;
                end
            endcase
        end
        // motion accumulation; a new delta wins over a clear
        if (clr) begin
            d.dx = RESET_WORD;
            d.dy = RESET_WORD;
            d.mot = 1'b0;
            d.rmask = 4'h0;
        end
        if (delta_add_i) begin
            d.dx = d.dx + delta_x_i;
            d.dy = d.dy + delta_y_i;
            d.mot = 1'b1;
        end
        d.mot_n = ~d.mot;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= DEV_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state
    assign link.miso_dat = q.miso;
    assign link.miso_oe = q.oe;
    assign reg_addr_o = q.raddr;
    assign reg_wr_o = q.wr;
    assign reg_wdata_o = q.wdata;
    assign motion_n_o = q.mot_n;
endmodule
`default_nettype wire

// ==== core/mss_pkg.sv ====
/*
 * mss_pkg: shared constants, timing counts and state types for the
 * motion sensor serial port (sensor end and host end).
 * Assumes a 10 MHz system clock on both ends.
 */
package mss_pkg;
    // -------------------------------------------------------------
    // register addresses and byte layout
    // -------------------------------------------------------------
    localparam logic [6:0] MOTION_ADDR = 7'h02;
    localparam logic [6:0] DX_L_ADDR = 7'h03;
    localparam logic [6:0] DX_H_ADDR = 7'h04;
    localparam logic [6:0] DY_L_ADDR = 7'h05;
    localparam logic [6:0] DY_H_ADDR = 7'h06;
    localparam logic [6:0] BURST_ADDR = 7'h50;
    localparam int DIR_BIT = 7;
    localparam int MOT_BIT = 7;
    localparam int BURST_BYTES = 14;
    localparam logic [3:0] ALL_DELTAS_READ = 4'hF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // -------------------------------------------------------------
    // timing, in ns and in system clock cycles
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_HALF_NS = 800;
    localparam int READ_ADDR_TO_DATA_GAP_NS = 100000;
    localparam int READ_TO_READ_GAP_NS = 20000;
    localparam int READ_TO_WRITE_GAP_NS = 20000;
    localparam int WRITE_GAP_NS = 20000;
    localparam int BURST_EXIT_HOLD_NS = 500;
    localparam int FRAME_WAIT_NS = 500000;

    // least time, rounded up, never below one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int SCLK_HALF_CYC = cyc_min(SCLK_HALF_NS);
    localparam int RAD_CYC = cyc_min(READ_ADDR_TO_DATA_GAP_NS);
    localparam int FRAME_CYC = cyc_min(FRAME_WAIT_NS);
    localparam int GAP_CYC = max2(max2(cyc_min(READ_TO_READ_GAP_NS), cyc_min(READ_TO_WRITE_GAP_NS)),
        max2(cyc_min(WRITE_GAP_NS), cyc_min(BURST_EXIT_HOLD_NS)));

    // -------------------------------------------------------------
    // state types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        MSS_D_IDLE = 3'b000,
        MSS_D_ADDR = 3'b001,
        MSS_D_WDATA = 3'b010,
        MSS_D_RDATA = 3'b011,
        MSS_D_BURST = 3'b100,
        MSS_D_LOCK = 3'b101
    } mss_dst_e;

    typedef enum logic [2:0] {
        MSS_H_IDLE = 3'b000,
        MSS_H_START = 3'b001,
        MSS_H_LOW = 3'b010,
        MSS_H_HIGH = 3'b011,
        MSS_H_WAIT = 3'b100,
        MSS_H_END = 3'b101
    } mss_hst_e;
endpackage

// ==== core/mss_if.sv ====
/*
 * mss_if: the four-wire serial link between host and sensor.
 * The shared data-out wire idles high when the sensor does not drive it.
 */
`timescale 1ns/10ps
`default_nettype none
interface mss_if;
    logic sclk;
    logic mosi;
    logic port_select_n;
    logic miso_dat;
    logic miso_oe;
    logic miso;

    // resolved data-out wire, pulled high when released
    assign miso = miso_oe ? miso_dat : 1'b1;

    modport host (output sclk, output mosi, output port_select_n, input miso);
    modport sensor (input sclk, input mosi, input port_select_n, output miso_dat, output miso_oe);
endinterface
`default_nettype wire

// ==== core/mss_sync.sv ====
/*
 * mss_sync: two-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; no word coherence is given.
 */
`timescale 1ns/10ps
`default_nettype none
module mss_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mss_sync_s;

    mss_sync_s q;
    mss_sync_s d;

    // first stage feeds only the second
    always_comb begin
        d.s1 = d_i;
        d.s2 = q.s1;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= '{s1: INIT, s2: INIT};
        end else begin
            q <= d;
        end
    end

    assign q_o = q.s2;
endmodule
`default_nettype wire

// ==== core/mss_host.sv ====
/*
 * mss_host: host end of the serial port; runs one command at a time,
 * makes the serial clock by dividing its own clock.
 * Assumes command inputs are on ref_clk_i and held while cmd_valid_i
 * is high and until busy_o falls; cmd_wdata_i is taken after the address byte.
 */
`timescale 1ns/10ps
`default_nettype none
module mss_host #(
    parameter int HALF_CYC = mss_pkg::SCLK_HALF_CYC,
    parameter int RAD_CYC = mss_pkg::RAD_CYC,
    parameter int FRAME_CYC = mss_pkg::FRAME_CYC,
    parameter int GAP_CYC = mss_pkg::GAP_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // serial link
    mss_if.host link,
    // command
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_burst_i,
    input wire logic [6:0] cmd_addr_i,
    input wire logic [7:0] cmd_wdata_i,
    input wire logic [3:0] cmd_len_i,
    // answer
    output logic busy_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic rvalid_o
);
    import mss_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mss_hst_e st;
        logic sclk;
        logic mosi;
        logic sel_n;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [2:0] bitn;
        logic [3:0] left;
        logic dphase;
        logic wr;
        logic burst;
        logic [15:0] tmr;
        logic busy;
        logic done;
        logic rvalid;
        logic [7:0] rdata;
    } mss_host_s;

    localparam mss_host_s HOST_RST = '{
        st: MSS_H_IDLE, sclk: 1'b1, mosi: 1'b0, sel_n: 1'b1, tx: RESET_BYTE,
        rx: RESET_BYTE, bitn: 3'h0, left: 4'h0, dphase: 1'b0, wr: 1'b0,
        burst: 1'b0, tmr: 16'h0000, busy: 1'b0, done: 1'b0, rvalid: 1'b0,
        rdata: RESET_BYTE};

    mss_host_s q;
    mss_host_s d;
    logic miso_s;
    logic tdone;

    // data-out comes from the other domain
    mss_sync #(.W(1), .INIT(1'b1)) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .d_i(link.miso),
        .q_o(miso_s)
    );

    assign tdone = (q.tmr == 16'h0000);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rvalid = 1'b0;
        if (!tdone) begin
            d.tmr = q.tmr - 16'h0001;
        end
        case (q.st)
            MSS_H_IDLE: begin
                if (cmd_valid_i) begin
                    d.st = MSS_H_START;
                    d.busy = 1'b1;
                    d.sel_n = 1'b0;
                    d.wr = cmd_write_i;
                    d.burst = cmd_burst_i & ~cmd_write_i;
                    d.tx = {cmd_write_i, (cmd_burst_i & ~cmd_write_i) ? BURST_ADDR : cmd_addr_i};
                    d.left = (cmd_burst_i & ~cmd_write_i & (cmd_len_i != 4'h0)) ? cmd_len_i : 4'h1;
                    d.dphase = 1'b0;
                    d.bitn = 3'h0;
                    d.tmr = 16'(HALF_CYC - 1);
                end
            end
            MSS_H_START, MSS_H_WAIT: begin
                if (tdone) begin
                    d.st = MSS_H_LOW;
                    d.sclk = 1'b0;
                    d.mosi = q.tx[7];
                    d.tmr = 16'(HALF_CYC - 1);
                end
            end
            MSS_H_LOW: begin
                if (tdone) begin
                    d.st = MSS_H_HIGH;
                    d.sclk = 1'b1;
                    d.rx = {q.rx[6:0], miso_s};
                    d.tmr = 16'(HALF_CYC - 1);
                end
            end
            MSS_H_HIGH: begin
                if (tdone) begin
                    d.tx = {q.tx[6:0], 1'b0};
                    d.bitn = q.bitn + 3'h1;
                    d.tmr = 16'(HALF_CYC - 1);
                    if (q.bitn != 3'h7) begin
                        d.st = MSS_H_LOW;
                        d.sclk = 1'b0;
                        d.mosi = q.tx[6];
                    end else if (!q.dphase) begin
                        d.dphase = 1'b1;
                        if (q.wr) begin
                            d.tx = cmd_wdata_i;
                            d.st = MSS_H_LOW;
                            d.sclk = 1'b0;
                            d.mosi = cmd_wdata_i[7];
                        end else begin
                            d.st = MSS_H_WAIT;
                            d.tmr = q.burst ? 16'(FRAME_CYC - 1) : 16'(RAD_CYC - 1);
                        end
                    end else begin
                        if (!q.wr) begin
                            d.rdata = q.rx;
                            d.rvalid = 1'b1;
                        end
                        d.left = q.left - 4'h1;
                        if (q.left == 4'h1) begin
                            d.st = MSS_H_END;
                            d.sel_n = 1'b1;
                            d.tmr = 16'(GAP_CYC - 1);
                        end else begin
                            d.st = MSS_H_LOW;
                            d.sclk = 1'b0;
                        end
                    end
                end
            end
            MSS_H_END: begin
                if (tdone) begin
                    d.st = MSS_H_IDLE;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end
            end
            default: begin
                d = HOST_RST;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q <= HOST_RST;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state
    assign link.sclk = q.sclk;
    assign link.mosi = q.mosi;
    assign link.port_select_n = q.sel_n;
    assign busy_o = q.busy;
    assign done_o = q.done;
    assign rdata_o = q.rdata;
    assign rvalid_o = q.rvalid;
endmodule
`default_nettype wire

// ==== testbench/mss_checker.sv ====
/* mss_checker: wire-level assertions on the host-to-sensor link.
   Assumes the host divides its clock by 8 per serial half period. */
`timescale 1ns/10ps
`default_nettype none
module mss_checker (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // link wires
    input wire logic sclk,
    input wire logic mosi,
    input wire logic port_select_n,
    input wire logic miso_dat,
    input wire logic miso_oe,
    input wire logic miso
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic sclk_q;
    logic [2:0] bits_q;
    // counts serial rising edges inside a select-low frame
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_q <= 1'h1;
            bits_q <= 3'h0;
        end else begin
            sclk_q <= sclk;
            if (port_select_n)
                bits_q <= 3'h0;
            else if (sclk && !sclk_q)
                bits_q <= bits_q + 3'h1;
        end
    end
    a_release_idle: assert property (port_select_n [*6] |-> !miso_oe && miso)
        else $error("data out driven while deselected");
    a_sclk_idle_high: assert property (port_select_n |-> sclk)
        else $error("serial clock low outside a frame");
    a_whole_bytes: assert property ($rose(port_select_n) |-> bits_q == 3'h0)
        else $error("frame ended mid-byte");
    a_low_phase: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
        else $error("serial low phase not eight cycles");
    a_mosi_steady: assert property (!port_select_n && $past(!port_select_n) && sclk && $past(sclk)
        |-> $stable(mosi))
        else $error("data in moved while clock high");
    a_miso_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_dat)
        |-> !$past(sclk, 3))
        else $error("data out moved away from a falling edge");
    a_oe_in_low: assert property ($rose(miso_oe) |-> !sclk && !port_select_n)
        else $error("data out enabled outside a read phase");
    a_exit_hold: assert property ($rose(port_select_n) |-> port_select_n [*5])
        else $error("select high too briefly");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
/* testbench: host and sensor ends joined by the link; host commands in,
   sensor strobes, read bytes and motion pin checked.
   Assumes mss_pkg, mss_if and both ends are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mss_pkg::*;
    logic ref_clk_i = '0, reset_n_i = '0, delta_add_i = '0;
    logic cmd_valid_i = '0, cmd_write_i = '0, cmd_burst_i = '0;
    logic [6:0] cmd_addr_i = '0, reg_addr_o;
    logic [7:0] cmd_wdata_i = '0, rdata_o, reg_wdata_o, reg_rdata_i;
    logic [3:0] cmd_len_i = '0;
    logic [15:0] delta_x_i = 16'h1234, delta_y_i = 16'hFEDC;
    logic [7:0] observation_i = 8'h11, surface_quality_i = 8'h22, pixel_sum_i = 8'h33;
    logic [7:0] max_pixel_i = 8'h44, min_pixel_i = 8'h05;
    logic [15:0] shutter_i = 16'h6677, frame_period_i = 16'h8899;
    logic busy_o, done_o, rvalid_o, reg_wr_o, motion_n_o;
    logic [7:0] rq[$], wa[$], wd[$];
    logic [7:0] bx[14] = '{8'h80, 8'h11, 8'h34, 8'h12, 8'hDC, 8'hFE, 8'h22,
        8'h33, 8'h44, 8'h05, 8'h66, 8'h77, 8'h88, 8'h99};
    int mismatches = 0, total_checks = 0;
    mss_if link ();
    mss_host #(.HALF_CYC(8), .RAD_CYC(20), .FRAME_CYC(20), .GAP_CYC(10)) mss_host_inst (.ref_clk_i,
        .reset_n_i, .link, .cmd_valid_i, .cmd_write_i, .cmd_burst_i, .cmd_addr_i, .cmd_wdata_i,
        .cmd_len_i, .busy_o, .done_o, .rdata_o, .rvalid_o);
    mss_sensor mss_sensor_inst (.ref_clk_i, .reset_n_i, .link, .delta_add_i, .delta_x_i,
        .delta_y_i, .observation_i, .surface_quality_i, .pixel_sum_i, .max_pixel_i, .min_pixel_i,
        .shutter_i, .frame_period_i, .reg_addr_o, .reg_wr_o, .reg_wdata_o, .reg_rdata_i,
        .motion_n_o);
    mss_checker mss_checker_inst (.ref_clk_i, .reset_n_i, .sclk(link.sclk), .mosi(link.mosi),
        .port_select_n(link.port_select_n), .miso_dat(link.miso_dat), .miso_oe(link.miso_oe),
        .miso(link.miso));
    // other registers answer with their address scrambled
    assign reg_rdata_i = {1'h0, reg_addr_o} ^ 8'h5A;
    always #50 ref_clk_i = ~ref_clk_i;
    // collect read bytes and sensor write strobes
    always @(negedge ref_clk_i) begin
        if (rvalid_o === 1'h1)
            rq.push_back(rdata_o);
        if (reg_wr_o === 1'h1) begin
            wa.push_back({1'h0, reg_addr_o});
            wd.push_back(reg_wdata_o);
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chm(input logic e);
        chk({7'h0, motion_n_o}, {7'h0, e});
    endtask
    // one host command, held until the host finishes it
    task automatic cmd(input logic w, input logic b, input logic [6:0] a, input logic [7:0] d,
        input logic [3:0] n);
        int i;
        @(negedge ref_clk_i);
        {cmd_write_i, cmd_burst_i, cmd_addr_i, cmd_wdata_i, cmd_len_i} = {w, b, a, d, n};
        cmd_valid_i = 1'h1;
        @(negedge ref_clk_i);
        cmd_valid_i = 1'h0;
        chk({7'h0, busy_o}, 8'h01);
        for (i = 0; i < 5000 && done_o !== 1'h1; i++)
            @(negedge ref_clk_i);
        if (done_o !== 1'h1) begin
            mismatches++;
            $display("BAD t=%0t command never finished", $time);
        end
        chk({7'h0, busy_o}, 8'h00);
    endtask
    // one movement report, then motion pin low
    task automatic move;
        @(negedge ref_clk_i);
        delta_add_i = 1'h1;
        @(negedge ref_clk_i);
        delta_add_i = 1'h0;
        @(negedge ref_clk_i);
        chm(1'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish;
    end
    initial begin
        repeat (6) @(negedge ref_clk_i);
        reset_n_i = 1'h1;
        chm(1'h1);
        cmd(1, 0, 7'h15, 8'hA5, 0);
        chk(wa.pop_front(), 8'h15);
        chk(wd.pop_front(), 8'hA5);
        $display("write test finished");
        cmd(0, 0, 7'h2B, 0, 0);
        chk(rq.pop_front(), 8'h71);
        $display("read test finished");
        move;
        cmd(0, 1, BURST_ADDR, 0, 4'hE);
        foreach (bx[i])
            chk(rq.pop_front(), bx[i]);
        chm(1'h1);
        $display("burst test finished");
        move;
        cmd(1, 0, MOTION_ADDR, 8'h00, 0);
        chm(1'h1);
        cmd(0, 0, MOTION_ADDR, 0, 0);
        chk(rq.pop_front(), 8'h00);
        $display("motion clear test finished");
        move;
        cmd(0, 0, DX_L_ADDR, 0, 0);
        chk(rq.pop_front(), 8'h34);
        cmd(0, 0, DX_H_ADDR, 0, 0);
        chk(rq.pop_front(), 8'h12);
        cmd(0, 0, DY_L_ADDR, 0, 0);
        chk(rq.pop_front(), 8'hDC);
        chm(1'h0);
        cmd(0, 0, DY_H_ADDR, 0, 0);
        chk(rq.pop_front(), 8'hFE);
        chm(1'h1);
        $display("delta read test finished");
        tally_and_finish;
    end
endmodule
`default_nettype wire
